// file: pkg/wsp_pkg.sv
package wsp_pkg;
  // Answer buffer, sent from the top byte down
  localparam int MSG_BYTES = 80;
  localparam logic [6:0] MSG_LAST = 7'h4f;
  // Characters
  localparam logic [7:0] CH_STAR = 8'h2a;
  localparam logic [7:0] CH_EQ = 8'h3d;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_PLUS = 8'h2b;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_DOT = 8'h2e;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_ONE = 8'h31;
  localparam logic [7:0] CH_ZERO = 8'h30;
  // Two-letter command codes
  localparam logic [15:0] CODE_UNLOCK = 16'h4557;
  localparam logic [15:0] CODE_NMEA = 16'h5039;
  localparam logic [15:0] CODE_FIXED = 16'h4c31;
  localparam logic [15:0] CODE_VERSION = 16'h5652;
  localparam logic [15:0] CODE_HEADER = 16'h4e48;
  localparam logic [15:0] CODE_TEMP = 16'h5454;
  localparam logic [15:0] CODE_TEMP_ALT = 16'h4131;
  localparam logic [15:0] CODE_HUM = 16'h5248;
  localparam logic [15:0] CODE_HUM_ALT = 16'h4132;
  localparam logic [15:0] CODE_RAW_T = 16'h4e31;
  localparam logic [15:0] CODE_RAW_H = 16'h4e32;
  localparam logic [15:0] CODE_RES = 16'h4152;
  localparam logic [15:0] CODE_MODE = 16'h4d44;
  // Coefficients: zero, span, then channel 1 and channel 2 sets
  localparam int NUM_COEF = 14;
  localparam logic [15:0] COEF_CODE [NUM_COEF] = '{
    16'h5a31, 16'h5a32, 16'h4d31, 16'h4d32,
    16'h4531, 16'h4631, 16'h4731, 16'h4831, 16'h4b31,
    16'h4532, 16'h4632, 16'h4732, 16'h4832, 16'h4b32};
  localparam logic [63:0] COEF_RST = 64'h30;
  // Sentence header, right aligned, leading nulls unused
  localparam logic [55:0] HDR_RST = 56'h24_57_49;
  localparam logic [7:0] HDR_MIN_CH = 8'h20;
  localparam logic [7:0] HDR_MAX_CH = 8'h5a;
  localparam logic [3:0] HDR_MAX_LEN = 4'h7;
  // Modes and limits
  localparam logic [3:0] SCALE_BAR = 4'h3;
  localparam logic [3:0] FAN_MODE = 4'h4;
  localparam logic [15:0] FIXED_MIN_REV = 16'h0102;
  // Reset values
  localparam logic [3:0] SCALE_RST = 4'h3;
  localparam logic [7:0] DEV_ADDR_RST = 8'h01;
  localparam logic RES_RST = 1'b1;
  localparam logic [3:0] MODE_RST = 4'h0;
  // Wishbone byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_REV = 8'h08;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FRAME = 3'b001,
    ST_TAIL = 3'b010,
    ST_VALUE = 3'b011,
    ST_SEND = 3'b100
  } wsp_state_t;

  // Measurements in BCD, most significant digit first
  typedef struct packed {
    logic p_neg;
    logic [31:0] press;
    logic t_neg;
    logic [15:0] temp;
    logic [15:0] hum;
    logic [23:0] serial;
    logic [27:0] raw_t;
    logic [27:0] raw_h;
    logic fan_ok;
  } wsp_meas_t;
endpackage

// file: verilog/wsp_parser.sv
`timescale 1ns/1ps
module wsp_parser #(
  parameter logic [15:0] FW_REV = 16'h0102
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Wishbone slave
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_stb_i,
  input wire logic wb_cyc_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Command bytes in
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic rx_ready,
  // Answer bytes out
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  // Measurements
  input wire wsp_pkg::wsp_meas_t meas,
  // Coefficients and settings for the conversion arithmetic
  input wire logic [3:0] coef_idx,
  output logic [63:0] coef_data,
  output logic res_sel,
  output logic [3:0] mode
);

  function automatic logic [7:0] dg(input logic [3:0] d);
    return {4'h3, d};
  endfunction

  wsp_pkg::wsp_state_t state_reg, state_next;
  logic [2:0] idx_reg, idx_next;
  logic [47:0] fr_reg, fr_next;
  logic [63:0] val_reg, val_next;
  logic [3:0] len_reg, len_next;
  logic bad_reg, bad_next;
  logic has_reg, has_next;
  logic unlock_reg, unlock_next;
  logic res_reg, res_next;
  logic [3:0] mode_reg, mode_next;
  logic [55:0] hdr_reg, hdr_next;
  logic [63:0] coef_reg [wsp_pkg::NUM_COEF];
  logic [63:0] coef_next [wsp_pkg::NUM_COEF];
  logic [639:0] msg_reg, msg_next;
  logic [6:0] pos_reg, pos_next;
  logic [7:0] tx_data_reg, tx_data_next;
  logic tx_valid_reg, tx_valid_next;
  logic rx_ready_reg;
  logic [7:0] refused_reg, refused_next;
  logic [7:0] cmds_reg, cmds_next;
  logic [63:0] coef_data_reg, coef_data_next;
  logic [3:0] scale_reg, scale_next;
  logic [7:0] dev_addr_reg, dev_addr_next;
  logic [31:0] wb_dat_reg, wb_dat_next;
  logic wb_ack_reg, wb_ack_next;

  logic rx_take, fan_flag, dest_ok, exec, send, done, is_coef;
  logic [3:0] ci;
  logic [7:0] cur;
  logic [15:0] code;
  logic [39:0] prefix;
  logic [47:0] sn_txt;
  logic [63:0] p_dig;
  logic [55:0] raw_t_txt, raw_h_txt;
  logic [55:0] t_txt;
  logic [47:0] fx_t, fx_h;
  logic [39:0] h_txt;
  logic [79:0] p_txt, fx_p;

  assign rx_take = rx_valid & rx_ready_reg;
  assign code = fr_reg[15:0];
  // Answer swaps the two address fields
  assign prefix = {wsp_pkg::CH_STAR, fr_reg[31:16], fr_reg[47:32]};
  assign dest_ok = fr_reg[47:32] ==
    {4'h3, dev_addr_reg[7:4], 4'h3, dev_addr_reg[3:0]};
  assign cur = msg_reg[{pos_reg, 3'b000} +: 8];

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_dig
      assign p_dig[gi*8 +: 8] = dg(meas.press[gi*4 +: 4]);
      if (gi < 7) begin : g_raw
        assign raw_t_txt[gi*8 +: 8] = dg(meas.raw_t[gi*4 +: 4]);
        assign raw_h_txt[gi*8 +: 8] = dg(meas.raw_h[gi*4 +: 4]);
      end
      if (gi < 6) begin : g_sn
        assign sn_txt[gi*8 +: 8] = dg(meas.serial[gi*4 +: 4]);
      end
    end
  endgenerate

  assign fan_flag = (mode_reg == wsp_pkg::FAN_MODE) & ~meas.fan_ok;
  // Nulls are skipped on output, so optional characters become 00
  assign t_txt = {meas.t_neg ? wsp_pkg::CH_MINUS : 8'h00,
    (meas.temp[15:12] != 4'h0) ? dg(meas.temp[15:12]) : 8'h00,
    dg(meas.temp[11:8]), wsp_pkg::CH_DOT, dg(meas.temp[7:4]),
    res_reg ? dg(meas.temp[3:0]) : 8'h00,
    fan_flag ? wsp_pkg::CH_PLUS : 8'h00};
  assign h_txt = {(meas.hum[15:12] != 4'h0) ? dg(meas.hum[15:12]) : 8'h00,
    (meas.hum[15:8] != 8'h00) ? dg(meas.hum[11:8]) : 8'h00,
    dg(meas.hum[7:4]), wsp_pkg::CH_DOT, dg(meas.hum[3:0])};
  assign p_txt = {meas.p_neg ? wsp_pkg::CH_MINUS : 8'h00,
    p_dig[63:48], wsp_pkg::CH_DOT, p_dig[47:0]};
  // Fixed record keeps every digit so the point never moves
  assign fx_p = {meas.p_neg ? wsp_pkg::CH_MINUS : wsp_pkg::CH_PLUS,
    p_dig[63:48], wsp_pkg::CH_DOT, p_dig[47:0]};
  assign fx_t = {meas.t_neg ? wsp_pkg::CH_MINUS : wsp_pkg::CH_PLUS,
    dg(meas.temp[15:12]), dg(meas.temp[11:8]), wsp_pkg::CH_DOT,
    dg(meas.temp[7:4]), dg(meas.temp[3:0])};
  assign fx_h = {wsp_pkg::CH_PLUS, dg(meas.hum[15:12]),
    dg(meas.hum[11:8]), dg(meas.hum[7:4]), wsp_pkg::CH_DOT,
    dg(meas.hum[3:0])};

  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    fr_next = fr_reg;
    val_next = val_reg;
    len_next = len_reg;
    bad_next = bad_reg;
    has_next = has_reg;
    unlock_next = unlock_reg;
    res_next = res_reg;
    mode_next = mode_reg;
    hdr_next = hdr_reg;
    coef_next = coef_reg;
    msg_next = msg_reg;
    pos_next = pos_reg;
    tx_data_next = tx_data_reg;
    tx_valid_next = tx_valid_reg;
    refused_next = refused_reg;
    cmds_next = cmds_reg;
    exec = 1'b0;
    send = 1'b0;
    done = 1'b0;
    is_coef = 1'b0;
    ci = 4'h0;
    if (tx_valid_reg && tx_ready) begin
      tx_valid_next = 1'b0;
    end
    if (state_reg == wsp_pkg::ST_SEND) begin
      if (!tx_valid_reg || tx_ready) begin
        if (cur != 8'h00) begin
          tx_data_next = cur;
          tx_valid_next = 1'b1;
        end
        if (pos_reg == 7'h00) begin
          state_next = wsp_pkg::ST_IDLE;
        end else begin
          pos_next = pos_reg - 7'h01;
        end
      end
    end else if (rx_take) begin
      if (rx_data == wsp_pkg::CH_STAR) begin
        // A star after the unlock code carries the unlock onward
        unlock_next = (state_reg == wsp_pkg::ST_TAIL) && dest_ok &&
          (code == wsp_pkg::CODE_UNLOCK);
        state_next = wsp_pkg::ST_FRAME;
        idx_next = 3'h0;
        val_next = 64'h0;
        len_next = 4'h0;
        bad_next = 1'b0;
        has_next = 1'b0;
      end else begin
        case (state_reg)
          wsp_pkg::ST_FRAME: begin
            fr_next = {fr_reg[39:0], rx_data};
            idx_next = idx_reg + 3'h1;
            if (idx_reg == 3'h5) begin
              state_next = wsp_pkg::ST_TAIL;
            end
          end
          wsp_pkg::ST_TAIL: begin
            if (rx_data == wsp_pkg::CH_EQ) begin
              state_next = wsp_pkg::ST_VALUE;
              has_next = 1'b1;
            end else if (rx_data == wsp_pkg::CH_CR) begin
              exec = 1'b1;
            end
          end
          wsp_pkg::ST_VALUE: begin
            if (rx_data == wsp_pkg::CH_CR) begin
              exec = 1'b1;
            end else begin
              val_next = {val_reg[55:0], rx_data};
              if (len_reg != 4'hf) begin
                len_next = len_reg + 4'h1;
              end
              // Equals sign would be taken as a value split on readback
              if (rx_data < wsp_pkg::HDR_MIN_CH ||
                  rx_data > wsp_pkg::HDR_MAX_CH ||
                  rx_data == wsp_pkg::CH_EQ) begin
                bad_next = 1'b1;
              end
            end
          end
          default: begin
          end
        endcase
      end
    end
    if (exec) begin
      state_next = wsp_pkg::ST_IDLE;
      unlock_next = 1'b0;
      for (int i = 0; i < wsp_pkg::NUM_COEF; i++) begin
        if (code == wsp_pkg::COEF_CODE[i]) begin
          is_coef = 1'b1;
          ci = 4'(i);
        end
      end
      if (dest_ok) begin
        cmds_next = cmds_reg + 8'h01;
        send = 1'b1;
        case (code)
          wsp_pkg::CODE_NMEA: begin
            // Silent unless pressure is scaled in bar
            send = (scale_reg == wsp_pkg::SCALE_BAR);
            msg_next = 640'({hdr_reg, "XDR,P,", p_txt, ",B,", sn_txt,
              ",C,", t_txt, ",C,", sn_txt, ",H,", h_txt, ",P,", sn_txt,
              wsp_pkg::CH_CR, wsp_pkg::CH_LF});
          end
          wsp_pkg::CODE_FIXED: begin
            send = (FW_REV >= wsp_pkg::FIXED_MIN_REV);
            msg_next = 640'({wsp_pkg::CH_STAR, sn_txt, wsp_pkg::CH_COMMA,
              fx_p, wsp_pkg::CH_COMMA, fx_t, wsp_pkg::CH_COMMA, fx_h,
              wsp_pkg::CH_COMMA,
              meas.fan_ok ? wsp_pkg::CH_ONE : wsp_pkg::CH_ZERO,
              wsp_pkg::CH_CR, wsp_pkg::CH_LF});
          end
          wsp_pkg::CODE_TEMP, wsp_pkg::CODE_TEMP_ALT: begin
            msg_next = 640'({prefix, t_txt, wsp_pkg::CH_CR,
              wsp_pkg::CH_LF});
          end
          wsp_pkg::CODE_HUM, wsp_pkg::CODE_HUM_ALT: begin
            msg_next = 640'({prefix, h_txt, wsp_pkg::CH_CR,
              wsp_pkg::CH_LF});
          end
          wsp_pkg::CODE_RAW_T, wsp_pkg::CODE_RAW_H: begin
            msg_next = 640'({prefix,
              (code == wsp_pkg::CODE_RAW_T) ? raw_t_txt : raw_h_txt,
              wsp_pkg::CH_CR, wsp_pkg::CH_LF});
          end
          wsp_pkg::CODE_VERSION: begin
            msg_next = 640'({prefix, code, wsp_pkg::CH_EQ,
              dg(FW_REV[15:12]), dg(FW_REV[11:8]), wsp_pkg::CH_DOT,
              dg(FW_REV[7:4]), dg(FW_REV[3:0]),
              wsp_pkg::CH_CR, wsp_pkg::CH_LF});
          end
          wsp_pkg::CODE_RES: begin
            if (has_reg && unlock_reg) begin
              res_next = (val_reg[7:0] == wsp_pkg::CH_ONE);
              done = 1'b1;
            end
            msg_next = 640'({prefix, code, wsp_pkg::CH_EQ,
              dg({3'h0, res_next}), wsp_pkg::CH_CR,
              wsp_pkg::CH_LF});
          end
          wsp_pkg::CODE_MODE: begin
            if (has_reg && unlock_reg && val_reg[7:4] == 4'h3) begin
              mode_next = val_reg[3:0];
              done = 1'b1;
            end
            msg_next = 640'({prefix, code, wsp_pkg::CH_EQ,
              wsp_pkg::CH_ZERO, dg(mode_next), wsp_pkg::CH_CR,
              wsp_pkg::CH_LF});
          end
          wsp_pkg::CODE_HEADER: begin
            // Too long or bad characters leave the old header
            if (has_reg && unlock_reg && !bad_reg && len_reg != 4'h0 &&
                len_reg <= wsp_pkg::HDR_MAX_LEN) begin
              hdr_next = val_reg[55:0];
              done = 1'b1;
            end
            msg_next = 640'({prefix, code, wsp_pkg::CH_EQ, hdr_next,
              wsp_pkg::CH_CR, wsp_pkg::CH_LF});
          end
          default: begin
            send = is_coef;
            if (is_coef && has_reg && unlock_reg) begin
              coef_next[ci] = val_reg;
              done = 1'b1;
            end
            msg_next = 640'({prefix, code, wsp_pkg::CH_EQ,
              coef_next[ci], wsp_pkg::CH_CR, wsp_pkg::CH_LF});
          end
        endcase
        // A value that stored nothing counts as refused
        if (has_reg && !done) begin
          refused_next = refused_reg + 8'h01;
        end
        if (send) begin
          state_next = wsp_pkg::ST_SEND;
          pos_next = wsp_pkg::MSG_LAST;
        end
      end
    end
    coef_data_next = 64'h0;
    if (int'(coef_idx) < wsp_pkg::NUM_COEF) begin
      coef_data_next = coef_reg[coef_idx];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= wsp_pkg::ST_IDLE;
      idx_reg <= 3'h0;
      fr_reg <= 48'h0;
      val_reg <= 64'h0;
      len_reg <= 4'h0;
      bad_reg <= 1'b0;
      has_reg <= 1'b0;
      unlock_reg <= 1'b0;
      res_reg <= wsp_pkg::RES_RST;
      mode_reg <= wsp_pkg::MODE_RST;
      hdr_reg <= wsp_pkg::HDR_RST;
      for (int i = 0; i < wsp_pkg::NUM_COEF; i++) begin
        coef_reg[i] <= wsp_pkg::COEF_RST;
      end
      msg_reg <= 640'h0;
      pos_reg <= 7'h0;
      tx_data_reg <= 8'h0;
      tx_valid_reg <= 1'b0;
      rx_ready_reg <= 1'b0;
      refused_reg <= 8'h0;
      cmds_reg <= 8'h0;
      coef_data_reg <= 64'h0;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      fr_reg <= fr_next;
      val_reg <= val_next;
      len_reg <= len_next;
      bad_reg <= bad_next;
      has_reg <= has_next;
      unlock_reg <= unlock_next;
      res_reg <= res_next;
      mode_reg <= mode_next;
      hdr_reg <= hdr_next;
      coef_reg <= coef_next;
      msg_reg <= msg_next;
      pos_reg <= pos_next;
      tx_data_reg <= tx_data_next;
      tx_valid_reg <= tx_valid_next;
      // No buffer: input stalls while an answer goes out
      rx_ready_reg <= (state_next != wsp_pkg::ST_SEND);
      refused_reg <= refused_next;
      cmds_reg <= cmds_next;
      coef_data_reg <= coef_data_next;
    end
  end

  always_comb begin
    wb_ack_next = wb_cyc_i & wb_stb_i & ~wb_ack_reg;
    wb_dat_next = 32'h0;
    scale_next = scale_reg;
    dev_addr_next = dev_addr_reg;
    if (wb_ack_next) begin
      case (wb_adr_i)
        wsp_pkg::REG_CTRL: begin
          wb_dat_next = {16'h0, dev_addr_reg, 4'h0, scale_reg};
          if (wb_we_i && wb_sel_i[0]) begin
            scale_next = wb_dat_i[3:0];
          end
          if (wb_we_i && wb_sel_i[1]) begin
            dev_addr_next = wb_dat_i[15:8];
          end
        end
        wsp_pkg::REG_STATUS: begin
          wb_dat_next = {8'h0, cmds_reg, refused_reg, 1'b0,
            state_reg == wsp_pkg::ST_SEND, unlock_reg, res_reg, mode_reg};
        end
        wsp_pkg::REG_REV: begin
          wb_dat_next = {16'h0, FW_REV};
        end
        default: begin
          wb_dat_next = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wb_ack_reg <= 1'b0;
      wb_dat_reg <= 32'h0;
      scale_reg <= wsp_pkg::SCALE_RST;
      dev_addr_reg <= wsp_pkg::DEV_ADDR_RST;
    end else begin
      wb_ack_reg <= wb_ack_next;
      wb_dat_reg <= wb_dat_next;
      scale_reg <= scale_next;
      dev_addr_reg <= dev_addr_next;
    end
  end

  assign wb_dat_o = wb_dat_reg;
  assign wb_ack_o = wb_ack_reg;
  assign rx_ready = rx_ready_reg;
  assign tx_data = tx_data_reg;
  assign tx_valid = tx_valid_reg;
  assign coef_data = coef_data_reg;
  assign res_sel = res_reg;
  assign mode = mode_reg;

endmodule // wsp_parser

// file: tb/wsp_parser_props.sv
`timescale 1ns/1ps
module wsp_parser_props #(
  parameter logic [15:0] FW_REV = 16'h0102
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Wishbone
  input wire logic [7:0] wb_adr_i,
  input wire logic wb_we_i,
  input wire logic wb_stb_i,
  input wire logic wb_cyc_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Byte streams
  input wire logic rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  // Settings out
  input wire logic [3:0] coef_idx,
  input wire logic [63:0] coef_data,
  input wire logic res_sel,
  input wire logic [3:0] mode
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_cr_out;
    tx_valid && tx_ready && tx_data == wsp_pkg::CH_CR;
  endsequence
  sequence s_lf_next;
    ##1 tx_valid && tx_data == wsp_pkg::CH_LF;
  endsequence
  a_ack_timing: assert property (s_req |=> wb_ack_o)
    else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data without ack");
  a_rev_read: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i == wsp_pkg::REG_REV |-> wb_dat_o == {16'h0000, FW_REV})
    else $error("revision word wrong");
  a_unmapped_zero: assert property (wb_ack_o && wb_adr_i > 8'h08
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  a_tx_hold: assert property (tx_valid && !tx_ready
    |=> tx_valid && $stable(tx_data)) else $error("tx byte dropped");
  // Input reopens while the final LF may still wait for the sink
  a_rx_quiet: assert property (tx_valid && tx_data != wsp_pkg::CH_LF
    |-> !rx_ready) else $error("rx open while sending");
  a_crlf_end: assert property (s_cr_out |-> s_lf_next)
    else $error("CR not followed by LF");
  a_coef_none: assert property (coef_idx >= 4'he
    |=> coef_data == 64'h0) else $error("coefficient beyond table");
  a_rst_clear: assert property (disable iff (1'b0)
    sys_rst |=> !wb_ack_o && !tx_valid && wb_dat_o == 32'h0)
    else $error("outputs active in reset");
  a_rst_vals: assert property (disable iff (1'b0) $fell(sys_rst)
    |-> res_sel == wsp_pkg::RES_RST && mode == wsp_pkg::MODE_RST)
    else $error("settings not at reset value");
endmodule // wsp_parser_props

bind wsp_parser wsp_parser_props #(.FW_REV(FW_REV)) u_props (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .wb_adr_i(wb_adr_i),
  .wb_we_i(wb_we_i), .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_ready(rx_ready),
  .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .coef_idx(coef_idx), .coef_data(coef_data), .res_sel(res_sel),
  .mode(mode));

// file: tb/wsp_host.sv
`timescale 1ns/1ps
module wsp_host (
  // Clock
  input wire logic ref_clk,
  // Command bytes out
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  // Answer bytes in
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready
);
  string got = "";
  int lf_n = 0;
  logic slow = 1'b1;
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b1;
  end
  // Stalls every other cycle to stress the answer hold
  always @(posedge ref_clk) begin
    if (tx_valid && tx_ready) begin
      got = $sformatf("%s%c", got, tx_data);
      if (tx_data == wsp_pkg::CH_LF)
        lf_n++;
    end
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
  // Sends every byte of the string, so one call can carry several frames; single attached unit only
  task automatic send(input string s);
    int n;
    for (int i = 0; i < s.len(); i++) begin
      rx_data <= s[i];
      rx_valid <= 1'b1;
      n = 0;
      do @(posedge ref_clk); while (rx_ready !== 1'b1 && ++n < 500);
    end
    rx_valid <= 1'b0;
    // Released line shows the inverse, not a stale byte
    rx_data <= ~rx_data;
  endtask
endmodule // wsp_host

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_we_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic [31:0] wb_dat_o, q;
  logic wb_ack_o, rx_valid, rx_ready, tx_valid, tx_ready, res_sel;
  logic [7:0] rx_data, tx_data;
  logic [3:0] coef_idx = 4'hf;
  logic [3:0] mode;
  logic [63:0] coef_data;
  wsp_pkg::wsp_meas_t meas = '{p_neg: 1'b0, press: 32'h00995874,
    t_neg: 1'b0, temp: 16'h2345, hum: 16'h0457, serial: 24'h098765,
    raw_t: 28'h1234567, raw_h: 28'h0765432, fan_ok: 1'b1};
  int err_total = 0;
  int n_checks = 0;
  int cyc_n = 0;
  always #4 ref_clk = ~ref_clk;
  wsp_parser dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_we_i(wb_we_i), .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .meas(meas),
    .coef_idx(coef_idx), .coef_data(coef_data), .res_sel(res_sel),
    .mode(mode));
  wsp_host host (.ref_clk(ref_clk), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready));
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 30000) begin
      err_total++;
      wrap_up();
    end
  end
  function automatic string vis(string s);
    for (int i = 0; i < s.len(); i++)
      if (s[i] < 8'h20) s.putc(i, "~");
    return s;
  endfunction
  task automatic chk(string what, string seen, string exp);
    n_checks++;
    if (seen != exp) begin
      err_total++;
      $display("Error %s expected %s seen %s", vis(what), vis(exp),
        vis(seen));
    end
  endtask
  // Silence is judged after a fixed wait, so no-answer cases are slow
  task automatic cmd(string s, string e);
    int n, k;
    n = 0;
    k = host.lf_n;
    host.got = "";
    host.send(s);
    while (host.lf_n == k && n < 400) begin
      n++;
      @(posedge ref_clk);
    end
    chk(s, host.got, e);
  endtask
  task automatic wb(logic [7:0] a, logic we, logic [3:0] s, logic [31:0] d);
    int n;
    n = 0;
    wb_adr_i <= a;
    wb_we_i <= we;
    wb_sel_i <= s;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1 && ++n < 50);
    // A bus that never answers is a failure, not a skipped access
    if (n >= 50) begin
      err_total++;
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge ref_clk);
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    wb(8'h08, 1'b0, 4'hf, 32'h0);
    chk("rev", $sformatf("%h", q), "00000102");
    wb(8'h0c, 1'b0, 4'hf, 32'h0);
    chk("unmapped", $sformatf("%h", q), "00000000");
    cmd("*0100TT\r", "*000123.45\r\n");
    cmd("*0100A1\r", "*000123.45\r\n");
    cmd("*0100RH\r", "*000145.7\r\n");
    cmd("*0100A2\r", "*000145.7\r\n");
    cmd("*0100N1\r", "*00011234567\r\n");
    cmd("*0100N2\r", "*00010765432\r\n");
    cmd("*0100VR\r", "*0001VR=01.02\r\n");
    cmd("*0100L1\r", "*098765,+00.995874,+23.45,+045.7,1\r\n");
    cmd("*0200TT\r", "");
    for (int i = 0; i < wsp_pkg::NUM_COEF; i++) begin
      cmd($sformatf("*0100%s\r", wsp_pkg::COEF_CODE[i]),
        $sformatf("*0001%s=0\r\n", wsp_pkg::COEF_CODE[i]));
    end
    cmd("*0100EW*0100G2=123\r", "*0001G2=123\r\n");
    coef_idx <= 4'hb;
    repeat (2) @(posedge ref_clk);
    chk("coef", $sformatf("%h", coef_data), "0000000000313233");
    coef_idx <= 4'he;
    meas.t_neg <= 1'b1;
    meas.temp <= 16'h0512;
    meas.fan_ok <= 1'b0;
    cmd("*0100TT\r", "*0001-5.12\r\n");
    cmd("*0100L1\r", "*098765,+00.995874,-05.12,+045.7,0\r\n");
    cmd("*0100EW*0100MD=4\r", "*0001MD=04\r\n");
    cmd("*0100TT\r", "*0001-5.12+\r\n");
    cmd("*0100AR=0\r", "*0001AR=1\r\n");
    cmd("*0100EW*0100AR=0\r", "*0001AR=0\r\n");
    cmd("*0100A1\r", "*0001-5.1+\r\n");
    cmd("*0100RH\r", "*000145.7\r\n");
    cmd("*0100NH\r", "*0001NH=$WI\r\n");
    cmd("*0100EW*0100NH=$AB,\r", "*0001NH=$AB,\r\n");
    cmd("*0100EW*0100NH=$ab\r", "*0001NH=$AB,\r\n");
    cmd("*0100EW*0100NH=$A=B\r", "*0001NH=$AB,\r\n");
    cmd("*0100P9\r", {"$AB,XDR,P,00.995874,B,098765,C,-5.1+,C,",
      "098765,H,45.7,P,098765\r\n"});
    wb(8'h00, 1'b1, 4'h1, 32'h2);
    cmd("*0100P9\r", "");
    wb(8'h00, 1'b1, 4'h1, 32'h3);
    wb(8'h00, 1'b1, 4'h2, 32'h200);
    wb(8'h00, 1'b0, 4'hf, 32'h0);
    chk("ctrl", $sformatf("%h", q), "00000203");
    cmd("*0200TT\r", "*0002-5.1+\r\n");
    cmd("*0100TT\r", "");
    wb(8'h00, 1'b1, 4'h2, 32'h100);
    wb(8'h04, 1'b0, 4'hf, 32'h0);
    chk("status", $sformatf("%h", q[15:0]), "0304");
    wrap_up();
  end
endmodule // tb
